//--- sdp_pkg.sv
package sdp_pkg;

   // register bus
   localparam int           APB_AW           = 4;
   localparam logic [3:0]   OFS_CTRL         = 4'h0;
   localparam logic [3:0]   OFS_STATUS       = 4'h4;
   localparam logic [3:0]   OFS_SHIFT        = 4'h8;
   localparam logic [31:0]  CTRL_RESET       = 32'h0000_0001;

   // control field positions
   localparam int           CTRL_TEST_EN_BIT = 0;
   localparam int           CTRL_SLOCK_BIT   = 1;

   // status field positions
   localparam int           ST_M_LSB         = 0;
   localparam int           ST_N_LSB         = 8;
   localparam int           ST_RATIO_LSB     = 10;
   localparam int           ST_T_LSB         = 14;
   localparam int           ST_BYPASS_BIT    = 17;
   localparam int           ST_PLOAD_BIT     = 18;
   localparam int           ST_CNT_LSB       = 19;

   // divider fields
   localparam int           M_W              = 7;
   localparam int           N_W              = 2;
   localparam int           T_W              = 3;
   localparam int           RATIO_W          = 4;
   localparam int           SHIFT_LEN        = 12;
   localparam int           CNT_W            = 4;
   localparam logic [3:0]   SHIFT_FULL       = 4'hc;

   // serial word layout, first bit received ends up at the top
   localparam int           SW_T_LSB         = 9;
   localparam int           SW_N_LSB         = 7;
   localparam int           SW_M_LSB         = 0;

   // post divider select codes and ratios
   localparam logic [1:0]   NSEL_DIV2        = 2'h0;
   localparam logic [1:0]   NSEL_DIV4        = 2'h1;
   localparam logic [1:0]   NSEL_DIV8        = 2'h2;
   localparam logic [1:0]   NSEL_DIV1        = 2'h3;
   localparam logic [3:0]   RATIO_1          = 4'h1;
   localparam logic [3:0]   RATIO_2          = 4'h2;
   localparam logic [3:0]   RATIO_4          = 4'h4;
   localparam logic [3:0]   RATIO_8          = 4'h8;

   // test select codes
   localparam logic [2:0]   TSEL_SHIFT_OUT   = 3'h0;
   localparam logic [2:0]   TSEL_ONE         = 3'h1;
   localparam logic [2:0]   TSEL_REF_HALF    = 3'h2;
   localparam logic [2:0]   TSEL_MCOUNT      = 3'h3;
   localparam logic [2:0]   TSEL_SYNTHESIZED_OUTPUT        = 3'h4;
   localparam logic [2:0]   TSEL_ZERO        = 3'h5;
   localparam logic [2:0]   TSEL_BYPASS      = 3'h6;
   localparam logic [2:0]   TSEL_SYNTHESIZED_OUTPUT_DIV4   = 3'h7;

   // reset contents of the divider latches
   localparam logic [6:0]   M_RESET          = 7'h00;
   localparam logic [1:0]   N_RESET          = 2'h0;

endpackage : sdp_pkg

//--- sdp_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   // first stage feeds the second stage only
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : sdp_sync2
`default_nettype wire

//--- sdp_divcnt.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_divcnt #(
   parameter int W = 7
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         clear,
   input  wire logic         tick,
   input  wire logic [W-1:0] ratio,
   output logic              wrap,
   output logic              at_zero
);

   logic [W-1:0] count_reg;

   assign at_zero = (count_reg == '0);

   // ratio 0 or 1 wraps on every tick
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count_reg <= '0;
         wrap      <= 1'b0;
      end else begin
         wrap <= 1'b0;
         if (tick) begin
            if (count_reg == '0) begin
               count_reg <= (ratio > 1) ? W'(ratio - 1'b1) : '0;
               wrap      <= 1'b1;
            end else begin
               count_reg <= count_reg - 1'b1;
            end
         end
      end
   end

endmodule : sdp_divcnt
`default_nettype wire

//--- sdp_program_port.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_program_port
   import sdp_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [APB_AW-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                p_load,
   input  wire logic [M_W-1:0]      m_pin,
   input  wire logic [N_W-1:0]      n_pin,
   input  wire logic                s_clock,
   input  wire logic                s_data,
   input  wire logic                s_load,
   input  wire logic                ref_half,
   output logic      [M_W-1:0]      synth_mult_reg,
   output logic      [RATIO_W-1:0]  post_div_ratio_reg,
   output logic      [N_W-1:0]      post_sel_reg,
   output logic      [T_W-1:0]      test_sel_reg,
   output logic                     bypass_reg,
   output logic                     synth_out_reg,
   output logic                     test_out_reg
);

   localparam int PIN_W = M_W + N_W + 5;

   logic [PIN_W-1:0]     pins_s;
   logic [M_W-1:0]       m_s;
   logic [N_W-1:0]       n_s;
   logic                 pl_s;
   logic                 sc_s;
   logic                 sd_s;
   logic                 sl_s;
   logic                 rh_s;
   logic                 pl_d_reg;
   logic                 sc_d_reg;
   logic                 sl_d_reg;
   logic                 pl_rise;
   logic                 sc_rise;
   logic                 sc_edge;
   logic                 sl_fall;
   logic                 serial_ok;

   logic [SHIFT_LEN-1:0] shift_reg;
   logic [CNT_W-1:0]     bit_cnt_reg;
   logic [31:0]          ctrl_reg;

   logic [M_W-1:0]       m_next;
   logic [N_W-1:0]       n_next;
   logic [T_W-1:0]       t_next;
   logic [RATIO_W-1:0]   ratio_next;

   logic                 post_wrap;
   logic                 m_wrap;
   logic                 m_at_zero;
   logic                 synthesized_output_div_reg;
   logic [1:0]           synthesized_output_q_reg;
   logic                 test_next;

   logic                 apb_access;
   logic                 addr_hit;
   logic [31:0]          rdata_next;

   // all pins come from outside the clock domain
   sdp_sync2 #(
      .W (PIN_W)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({m_pin, n_pin, p_load, s_clock, s_data, s_load, ref_half}),
      .q   (pins_s)
   );

   assign {m_s, n_s, pl_s, sc_s, sd_s, sl_s, rh_s} = pins_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         pl_d_reg <= 1'b0;
         sc_d_reg <= 1'b0;
         sl_d_reg <= 1'b0;
      end else begin
         pl_d_reg <= pl_s;
         sc_d_reg <= sc_s;
         sl_d_reg <= sl_s;
      end
   end

   assign pl_rise   = pl_s & ~pl_d_reg;
   assign sc_rise   = sc_s & ~sc_d_reg;
   assign sc_edge   = sc_s ^ sc_d_reg;
   assign sl_fall   = ~sl_s & sl_d_reg;
   // software lock lets a host freeze the serial path during bring-up
   assign serial_ok = pl_s & ~ctrl_reg[CTRL_SLOCK_BIT];

   // serial shift register, first bit ends at the top
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_reg <= '0;
      end else if (sc_rise && serial_ok) begin
         shift_reg <= {shift_reg[SHIFT_LEN-2:0], sd_s};
      end
   end

   // bits seen since the last load, saturating at a full word
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt_reg <= '0;
      end else if (sl_fall && serial_ok) begin
         bit_cnt_reg <= '0;
      end else if (sc_rise && serial_ok && bit_cnt_reg != SHIFT_FULL) begin
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
   end

   // parallel capture wins over a coincident serial load
   always_comb begin
      m_next = synth_mult_reg;
      n_next = post_sel_reg;
      t_next = test_sel_reg;
      if (!pl_s) begin
         m_next = m_s;
         n_next = n_s;
         t_next = TSEL_SHIFT_OUT;
      end else if (pl_rise) begin
         m_next = m_s;
         n_next = n_s;
      end else if (sl_fall && serial_ok) begin
         t_next = shift_reg[SW_T_LSB +: T_W];
         n_next = shift_reg[SW_N_LSB +: N_W];
         m_next = shift_reg[SW_M_LSB +: M_W];
      end
   end

   always_comb begin
      case (n_next)
         NSEL_DIV2: ratio_next = RATIO_2;
         NSEL_DIV4: ratio_next = RATIO_4;
         NSEL_DIV8: ratio_next = RATIO_8;
         NSEL_DIV1: ratio_next = RATIO_1;
         default:   ratio_next = RATIO_2;
      endcase
   end

   // the analog loop multiplies by synth_mult_reg and divides by the ratio
   always_ff @(posedge clk) begin
      if (rst) begin
         synth_mult_reg     <= M_RESET;
         post_sel_reg       <= N_RESET;
         post_div_ratio_reg <= RATIO_2;
         test_sel_reg       <= TSEL_SHIFT_OUT;
         bypass_reg         <= 1'b0;
      end else begin
         synth_mult_reg     <= m_next;
         post_sel_reg       <= n_next;
         post_div_ratio_reg <= ratio_next;
         test_sel_reg       <= t_next;
         bypass_reg         <= (t_next == TSEL_BYPASS);
      end
   end

   // bypass: both serial clock edges feed the post divider, so the
   // output toggle gives serial clock divided by the ratio, even for 1
   sdp_divcnt #(
      .W (RATIO_W)
   ) u_post_div (
      .clk     (clk),
      .rst     (rst),
      .clear   (~bypass_reg),
      .tick    (sc_edge),
      .ratio   (post_div_ratio_reg),
      .wrap    (post_wrap),
      .at_zero ()
   );

   sdp_divcnt #(
      .W (M_W)
   ) u_m_div (
      .clk     (clk),
      .rst     (rst),
      .clear   (~bypass_reg),
      .tick    (post_wrap & ~synthesized_output_div_reg),
      .ratio   (synth_mult_reg),
      .wrap    (m_wrap),
      .at_zero (m_at_zero)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         synthesized_output_div_reg <= 1'b0;
      end else if (!bypass_reg) begin
         synthesized_output_div_reg <= 1'b0;
      end else if (post_wrap) begin
         synthesized_output_div_reg <= ~synthesized_output_div_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         synth_out_reg <= 1'b0;
         synthesized_output_q_reg    <= 2'h0;
      end else begin
         synth_out_reg <= synthesized_output_div_reg;
         if (synthesized_output_div_reg && post_wrap) begin
            synthesized_output_q_reg <= synthesized_output_q_reg + 1'b1;
         end
      end
   end

   // the m counter output is a narrow pulse, not a square wave
   always_comb begin
      case (test_sel_reg)
         TSEL_SHIFT_OUT: test_next = shift_reg[SHIFT_LEN-1];
         TSEL_ONE:       test_next = 1'b1;
         TSEL_REF_HALF:  test_next = rh_s;
         TSEL_MCOUNT:    test_next = m_at_zero;
         TSEL_SYNTHESIZED_OUTPUT:      test_next = synthesized_output_div_reg;
         TSEL_ZERO:      test_next = 1'b0;
         TSEL_BYPASS:    test_next = m_at_zero | m_wrap;
         TSEL_SYNTHESIZED_OUTPUT_DIV4: test_next = synthesized_output_q_reg[1];
         default:        test_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         test_out_reg <= 1'b0;
      end else begin
         test_out_reg <= test_next & ctrl_reg[CTRL_TEST_EN_BIT];
      end
   end

   // apb slave: one wait state, pready is registered
   assign apb_access = psel & penable & ~pready;
   assign addr_hit   = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                       (paddr == OFS_SHIFT);

   always_comb begin
      rdata_next = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: rdata_next = ctrl_reg;
         OFS_STATUS: begin
            rdata_next[ST_M_LSB +: M_W]           = synth_mult_reg;
            rdata_next[ST_N_LSB +: N_W]           = post_sel_reg;
            rdata_next[ST_RATIO_LSB +: RATIO_W]   = post_div_ratio_reg;
            rdata_next[ST_T_LSB +: T_W]           = test_sel_reg;
            rdata_next[ST_BYPASS_BIT]             = bypass_reg;
            rdata_next[ST_PLOAD_BIT]              = pl_s;
            rdata_next[ST_CNT_LSB +: CNT_W]       = bit_cnt_reg;
         end
         OFS_SHIFT: rdata_next[SHIFT_LEN-1:0] = shift_reg;
         default:   rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_access;
         pslverr <= apb_access & ~addr_hit;
         if (apb_access && !pwrite) begin
            prdata <= rdata_next;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (apb_access && pwrite && paddr == OFS_CTRL) begin
         ctrl_reg <= {30'h0000_0000, pwdata[1:0]};
      end
   end

   sequence s_serial_load;
      pl_s && sl_fall && !ctrl_reg[CTRL_SLOCK_BIT] && !pl_rise;
   endsequence

   sequence s_fields_moved;
      synth_mult_reg == $past(shift_reg[6:0]) &&
      post_sel_reg == $past(shift_reg[8:7]) &&
      test_sel_reg == $past(shift_reg[11:9]);
   endsequence

   a_transparent_pins: assert property (@(posedge clk) disable iff (rst)
      !pl_s |=> synth_mult_reg == $past(m_s) && post_sel_reg == $past(n_s))
      else $error("latches not transparent while parallel strobe low");

   a_parallel_capture: assert property (@(posedge clk) disable iff (rst)
      pl_rise |=> synth_mult_reg == $past(m_s) && post_sel_reg == $past(n_s))
      else $error("parallel capture missed");

   a_test_forced_zero: assert property (@(posedge clk) disable iff (rst)
      !pl_s |=> test_sel_reg == 3'h0 && !bypass_reg)
      else $error("test select not forced to zero");

   a_shift_step: assert property (@(posedge clk) disable iff (rst)
      sc_rise && serial_ok |=> shift_reg == {$past(shift_reg[10:0]), $past(sd_s)})
      else $error("serial bit not shifted in");

   a_shift_gated: assert property (@(posedge clk) disable iff (rst)
      !pl_s |=> $stable(shift_reg))
      else $error("shift register moved with parallel strobe low");

   a_serial_fields: assert property (@(posedge clk) disable iff (rst)
      s_serial_load |=> s_fields_moved)
      else $error("serial load did not move fields");

   a_hold_values: assert property (@(posedge clk) disable iff (rst)
      pl_s && !pl_rise && !sl_fall ##1 pl_s |->
      $stable(synth_mult_reg) && $stable(post_sel_reg))
      else $error("divider values changed without a load");

   a_ratio_decode: assert property (@(posedge clk) disable iff (rst)
      post_div_ratio_reg == ((post_sel_reg == 2'h3) ? 4'h1 : 4'h2 << post_sel_reg))
      else $error("post divider ratio decode wrong");

   a_bypass_decode: assert property (@(posedge clk) disable iff (rst)
      bypass_reg == (test_sel_reg == 3'h6))
      else $error("bypass flag does not follow test select");

   a_bypass_idle: assert property (@(posedge clk) disable iff (rst)
      !bypass_reg [*3] |-> !synth_out_reg)
      else $error("synthesized output toggles outside bypass");

endmodule : sdp_program_port
`default_nettype wire

//--- sdp_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_ctrl_model
   import sdp_pkg::*;
(
   input  wire logic         clk,
   output logic              p_load,
   output logic [M_W-1:0]    m_pin,
   output logic [N_W-1:0]    n_pin,
   output logic              s_clock,
   output logic              s_data,
   output logic              s_load
);
   initial begin
      p_load  = 1'b1;
      m_pin   = 7'h00;
      n_pin   = 2'h0;
      s_clock = 1'b0;
      s_data  = 1'b0;
      s_load  = 1'b0;
   end

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
   endtask : waitc

   // pins and strobe change on the same edge, then hold for five cycles
   task automatic set_pins(input logic pl, input logic [M_W-1:0] m, input logic [N_W-1:0] n);
      p_load <= pl;
      m_pin  <= m;
      n_pin  <= n;
      waitc(5);
   endtask : set_pins

   // slow shift clock, msb first; clock stands low between frames
   task automatic shift_bits(input logic [SHIFT_LEN-1:0] w);
      for (int i = SHIFT_LEN - 1; i >= 0; i--) begin
         s_data  <= w[i];
         waitc(3);
         s_clock <= 1'b1;
         waitc(3);
         s_clock <= 1'b0;
      end
      waitc(3);
      // released data line must not keep the last bit
      s_data <= ~w[0];
   endtask : shift_bits

   // full word then a load pulse; p_load left as the caller set it
   task automatic ser_load(input logic [SHIFT_LEN-1:0] w);
      shift_bits(w);
      s_load <= 1'b1;
      waitc(3);
      s_load <= 1'b0;
      waitc(5);
   endtask : ser_load
endmodule : sdp_ctrl_model
`default_nettype wire

//--- sdp_program_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sdp_program_port_tb
   import sdp_pkg::*;
;
   logic              clk;
   logic              rst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [3:0]        paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              p_load;
   logic [M_W-1:0]    m_pin;
   logic [N_W-1:0]    n_pin;
   logic              s_clock;
   logic              s_data;
   logic              s_load;
   logic [M_W-1:0]    mult;
   logic [RATIO_W-1:0] ratio;
   logic [N_W-1:0]    nsel;
   logic [T_W-1:0]    tsel;
   logic              byp;
   logic              sout;
   logic              sout_d;
   logic              tout;
   logic [31:0]       rd;
   logic              er;
   int                num_errors;
   int                tests_run;
   int                cyc;
   int                rises;

   sdp_program_port dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .p_load(p_load), .m_pin(m_pin), .n_pin(n_pin), .s_clock(s_clock),
      .s_data(s_data), .s_load(s_load), .ref_half(1'b0), .synth_mult_reg(mult),
      .post_div_ratio_reg(ratio), .post_sel_reg(nsel), .test_sel_reg(tsel),
      .bypass_reg(byp), .synth_out_reg(sout), .test_out_reg(tout));

   sdp_ctrl_model u_m (.clk(clk), .p_load(p_load), .m_pin(m_pin), .n_pin(n_pin),
      .s_clock(s_clock), .s_data(s_data), .s_load(s_load));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      sout_d <= sout;
      if (sout === 1'b1 && sout_d === 1'b0) begin
         rises <= rises + 1;
      end
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // called just after a rising edge; request held until pready is seen
   task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      chk("pready", 1, pready);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   function automatic logic [3:0] exp_ratio(input logic [1:0] n);
      case (n)
         2'h0: return 4'h2;
         2'h1: return 4'h4;
         2'h2: return 4'h8;
         default: return 4'h1;
      endcase
   endfunction : exp_ratio

   task automatic t_reset();
      chk("mult", 0, mult);
      chk("ratio", 4'h2, ratio);
      chk("tsel", 0, tsel);
      chk("bypass", 0, byp);
      apb(1'b0, OFS_CTRL, 0);
      chk("ctrl", 1, rd);
      apb(1'b0, 4'hc, 0);
      chk("slverr", 1, er);
   endtask : t_reset

   task automatic t_parallel();
      logic [6:0] m;
      for (int n = 0; n < 4; n++) begin
         m = 7'h19 + 7'(n * 9);
         u_m.set_pins(1'b0, m, 2'(n));
         u_m.set_pins(1'b1, m, 2'(n));
         chk("mult", m, mult);
         chk("nsel", n, nsel);
         chk("ratio", exp_ratio(2'(n)), ratio);
      end
      u_m.set_pins(1'b1, 7'h7f, 2'h0);
      chk("held mult", 7'h34, mult);
      chk("held ratio", 4'h1, ratio);
      u_m.set_pins(1'b0, 7'h30, 2'h0);
      chk("open mult", 7'h30, mult);
      chk("open ratio", 4'h2, ratio);
      u_m.set_pins(1'b1, 7'h30, 2'h0);
   endtask : t_parallel

   task automatic t_serial();
      u_m.ser_load({3'h5, 2'h1, 7'h2d});
      chk("ser mult", 7'h2d, mult);
      chk("ser nsel", 2'h1, nsel);
      chk("ser tsel", 3'h5, tsel);
      chk("tout zero", 0, tout);
      apb(1'b0, OFS_SHIFT, 0);
      chk("shift", 12'haad, rd[11:0]);
      apb(1'b0, OFS_STATUS, 0);
      chk("status", 32'h0005_512d, rd);
      apb(1'b1, OFS_CTRL, 32'h3);
      u_m.ser_load({3'h0, 2'h3, 7'h11});
      chk("locked mult", 7'h2d, mult);
      apb(1'b1, OFS_CTRL, 32'h1);
      // p_load low: serial path ignored, pins win, test select cleared
      u_m.set_pins(1'b0, 7'h22, 2'h2);
      chk("low tsel", 0, tsel);
      chk("low tout", 1, tout);
      u_m.ser_load({3'h1, 2'h3, 7'h11});
      chk("low mult", 7'h22, mult);
      chk("low ratio", 4'h8, ratio);
      u_m.set_pins(1'b1, 7'h22, 2'h2);
   endtask : t_serial

   task automatic t_bypass();
      u_m.ser_load({TSEL_BYPASS, NSEL_DIV2, 7'h04});
      chk("bypass", 1, byp);
      rises = 0;
      u_m.shift_bits(12'h000);
      chk("bypass clock", 1, rises >= 5 && rises <= 7);
      u_m.ser_load({3'h0, 2'h0, 7'h20});
      chk("bypass off", 0, byp);
      chk("mult back", 7'h20, mult);
   endtask : t_bypass

   initial begin
      rst        = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 4'h0;
      pwdata     = 32'h0;
      sout_d     = 1'b0;
      num_errors = 0;
      tests_run  = 0;
      cyc        = 0;
      rises      = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset();
      t_parallel();
      t_serial();
      t_bypass();
      give_verdict();
   end
endmodule : sdp_program_port_tb
`default_nettype wire
